// ### hdl/dee_cfg.svh
`ifndef DEE_CFG_SVH
`define DEE_CFG_SVH

// ==================================================
// Bus map
`define DEE_APB_AW 8
`define DEE_OFS_ADDR 8'h00
`define DEE_OFS_DATA 8'h04
`define DEE_OFS_CTRL 8'h08
`define DEE_OFS_STAT 8'h0C

// ==================================================
// Control word bit positions
`define DEE_C_FETCH_GO 0
`define DEE_C_FETCH_ALLOW 1
`define DEE_C_PROG_GO 2
`define DEE_C_PROG_ALLOW 3
`define DEE_C_PAGE_MODE 4
`define DEE_C_WIPE_GO 5
`define DEE_C_WIPE_ALLOW 6
`define DEE_C_TIMING 7

// ==================================================
// Status word bit positions
`define DEE_S_DONE 0
`define DEE_S_BUSY 1

// ==================================================
// Reset values and page geometry
`define DEE_RST_BYTE 8'h00
`define DEE_LOW_MAX 4'hF
`define DEE_TAG_NONE 16'h0000

// ==================================================
// Timing, in microseconds and kilohertz
`define DEE_CLK_KHZ 50000
`define DEE_ERASE_SHORT_US 3200
`define DEE_WRITE_SHORT_US 2200
`define DEE_ERASE_LONG_US 3700
`define DEE_WRITE_LONG_US 3000

`endif

// ### hdl/dee_ctrl.sv
`timescale 1ns/1ps
`include "dee_cfg.svh"
module dee_ctrl #(
   parameter int CNT_W = 18,
   parameter int ERASE_SHORT_CYC = `DEE_ERASE_SHORT_US * `DEE_CLK_KHZ / 1000,
   parameter int WRITE_SHORT_CYC = `DEE_WRITE_SHORT_US * `DEE_CLK_KHZ / 1000,
   parameter int ERASE_LONG_CYC = `DEE_ERASE_LONG_US * `DEE_CLK_KHZ / 1000,
   parameter int WRITE_LONG_CYC = `DEE_WRITE_LONG_US * `DEE_CLK_KHZ / 1000
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`DEE_APB_AW-1:0] paddr,
   input wire dee_pkg::dee_word_t pwdata,
   output dee_pkg::dee_word_t prdata,
   output logic pready,
   output logic pslverr,
   output logic nvmDoneFlag
);
   import dee_pkg::*;

   // ==================================================
   // State
   dee_state_t state, next_state;
   logic [6:0] addrReg, memWaddr;
   dee_byte_t dataReg, memWdata, memRdata;
   logic timingSel, wipeAllow, wipeGo, pageMode, programAllow, programGo, fetchAllow, fetchGo;
   logic [15:0] tagBuf;
   logic wipeAllowPrev, opWipe;
   logic [3:0] eraseIdx;

   logic idle, wrTake, addrWr, dataWr, ctrlWr, statWr, tagWr;
   logic startWipe, startProgram, startFetch, wipeEnd, progEnd, doneEvt;
   logic memWe, memRe, timerStart, timerDone, readHit;
   logic [CNT_W-1:0] timerLoad;
   dee_word_t readWord;

   // Lower field advance that parks at the page end
   function automatic logic [6:0] nextLow(input logic [6:0] a);
      nextLow = (a[3:0] == `DEE_LOW_MAX) ? a : {a[6:4], a[3:0] + 4'h1};
   endfunction

   // ==================================================
   // APB decode
   // Writes land at the edge where pready is seen high
   assign idle = (state == ST_IDLE);
   assign wrTake = psel && penable && pready && pwrite;
   // Address, data and control writes while busy are dropped so a cycle cannot be disturbed
   assign addrWr = wrTake && (paddr == `DEE_OFS_ADDR) && idle;
   assign dataWr = wrTake && (paddr == `DEE_OFS_DATA) && idle;
   assign ctrlWr = wrTake && (paddr == `DEE_OFS_CTRL) && idle;
   assign statWr = wrTake && (paddr == `DEE_OFS_STAT);
   assign tagWr = dataWr && pageMode;

   // Trigger qualification; one start at most per write
   assign startWipe = ctrlWr && pwdata[`DEE_C_WIPE_GO] && wipeAllow && pwdata[`DEE_C_PAGE_MODE];
   assign startProgram = ctrlWr && pwdata[`DEE_C_PROG_GO] && programAllow
      && !pwdata[`DEE_C_PAGE_MODE] && !startWipe;
   assign startFetch = ctrlWr && pwdata[`DEE_C_FETCH_GO] && fetchAllow
      && !startWipe && !startProgram;
   assign wipeEnd = (state == ST_WIPE_APPLY) && (eraseIdx == `DEE_LOW_MAX);
   assign progEnd = (state == ST_WR_WAIT) && timerDone;
   assign doneEvt = wipeEnd || progEnd;

   // Read mux; reserved bits read as zero
   always_comb begin
      readWord = '0;
      readHit = 1'b1;
      case (paddr)
         `DEE_OFS_ADDR: readWord[6:0] = addrReg;
         `DEE_OFS_DATA: readWord[7:0] = dataReg;
         `DEE_OFS_CTRL: readWord[7:0] = {timingSel, wipeAllow, wipeGo, pageMode,
            programAllow, programGo, fetchAllow, fetchGo};
         `DEE_OFS_STAT: begin
            readWord[`DEE_S_DONE] = nvmDoneFlag;
            readWord[`DEE_S_BUSY] = !idle;
         end
         default: readHit = 1'b0;
      endcase
   end

   // One wait state so that read data leaves a flip-flop
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         prdata <= (psel && penable && !pready && !pwrite) ? readWord : '0;
         pslverr <= psel && penable && !pready && !readHit;
      end
   end

   // ==================================================
   // Sequencer
   always_comb begin
      next_state = state;
      memWe = 1'b0;
      memWaddr = addrReg;
      memWdata = `DEE_RST_BYTE;
      memRe = 1'b0;
      timerStart = 1'b0;
      timerLoad = CNT_W'(ERASE_SHORT_CYC);
      case (state)
         ST_IDLE: begin
            if (startWipe) begin
               // Timing taken from the same write so a combined update is honoured
               timerStart = 1'b1;
               timerLoad = pwdata[`DEE_C_TIMING] ? CNT_W'(ERASE_LONG_CYC) : CNT_W'(ERASE_SHORT_CYC);
               next_state = ST_WIPE_WAIT;
            end else if (startProgram) begin
               next_state = ST_WR_CLEAR;
            end else if (startFetch) begin
               next_state = ST_RD_ISSUE;
            end
         end
         ST_RD_ISSUE: begin
            memRe = 1'b1;
            next_state = ST_RD_TAKE;
         end
         ST_RD_TAKE: next_state = ST_IDLE;
         ST_WIPE_WAIT: begin
            if (timerDone) begin
               next_state = ST_WIPE_APPLY;
            end
         end
         ST_WIPE_APPLY: begin
            // Walk all sixteen slots; only tagged ones are zeroed
            memWaddr = {addrReg[6:4], eraseIdx};
            memWe = tagBuf[eraseIdx];
            if (wipeEnd) begin
               next_state = ST_FINISH;
            end
         end
         ST_WR_CLEAR: begin
            memWe = 1'b1;
            timerStart = 1'b1;
            timerLoad = timingSel ? CNT_W'(WRITE_LONG_CYC) : CNT_W'(WRITE_SHORT_CYC);
            next_state = ST_WR_WAIT;
         end
         ST_WR_WAIT: begin
            if (timerDone) begin
               memWe = 1'b1;
               memWdata = dataReg;
               next_state = ST_FINISH;
            end
         end
         ST_FINISH: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Erase slot counter, parked at zero outside the apply phase
   always_ff @(posedge ref_clk) begin
      if (sys_rst || state != ST_WIPE_APPLY) begin
         eraseIdx <= 4'h0;
      end else begin
         eraseIdx <= eraseIdx + 4'h1;
      end
   end

   // Which allow bit the finish step drops
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         opWipe <= 1'b0;
      end else if (startWipe) begin
         opWipe <= 1'b1;
      end else if (startProgram) begin
         opWipe <= 1'b0;
      end
   end

   // ==================================================
   // Control bits: software sets; hardware clears the go bits and the wipe and program allow bits
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timingSel <= 1'b0;
         wipeAllow <= 1'b0;
         wipeGo <= 1'b0;
         pageMode <= 1'b0;
         programAllow <= 1'b0;
         programGo <= 1'b0;
         fetchAllow <= 1'b0;
         fetchGo <= 1'b0;
      end else begin
         if (ctrlWr) begin
            timingSel <= pwdata[`DEE_C_TIMING];
            wipeAllow <= pwdata[`DEE_C_WIPE_ALLOW];
            pageMode <= pwdata[`DEE_C_PAGE_MODE];
            programAllow <= pwdata[`DEE_C_PROG_ALLOW];
            fetchAllow <= pwdata[`DEE_C_FETCH_ALLOW];
         end
         // Starts need idle, so a start never meets its own end
         if (startWipe) begin
            wipeGo <= 1'b1;
         end else if (wipeEnd) begin
            wipeGo <= 1'b0;
         end
         if (startProgram) begin
            programGo <= 1'b1;
         end else if (progEnd) begin
            programGo <= 1'b0;
         end
         if (startFetch) begin
            fetchGo <= 1'b1;
         end else if (state == ST_RD_TAKE) begin
            fetchGo <= 1'b0;
         end
         // Allow bit drops one cycle after its go bit clears
         if (state == ST_FINISH) begin
            if (opWipe) begin
               wipeAllow <= 1'b0;
            end else begin
               programAllow <= 1'b0;
            end
         end
      end
   end

   // ==================================================
   // Address and data registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         addrReg <= 7'h00;
      end else if (addrWr) begin
         addrReg <= pwdata[6:0];
      end else if (tagWr) begin
         addrReg <= nextLow(addrReg);
      end else if (state == ST_RD_TAKE && pageMode) begin
         addrReg <= nextLow(addrReg);
      end
   end

   // Byte stays put until the next read or write
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dataReg <= `DEE_RST_BYTE;
      end else if (dataWr) begin
         dataReg <= pwdata[7:0];
      end else if (state == ST_RD_TAKE) begin
         dataReg <= memRdata;
      end
   end

   // ==================================================
   // Page tag buffer
   always_ff @(posedge ref_clk) begin
      wipeAllowPrev <= sys_rst ? 1'b0 : wipeAllow;
   end

   // A tag at the saturated slot is simply set again; clear beats tag
   always_ff @(posedge ref_clk) begin
      if (sys_rst || (wipeAllowPrev && !wipeAllow)) begin
         tagBuf <= `DEE_TAG_NONE;
      end else if (tagWr) begin
         tagBuf[addrReg[3:0]] <= 1'b1;
      end
   end

   // ==================================================
   // Done flag: set wins over a write-one clear
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         nvmDoneFlag <= 1'b0;
      end else if (doneEvt) begin
         nvmDoneFlag <= 1'b1;
      end else if (statWr && pwdata[`DEE_S_DONE]) begin
         nvmDoneFlag <= 1'b0;
      end
   end

   // ==================================================
   // Storage array and cycle timer
   dee_mem #(.AW(7), .DW(8)) u_mem (
      .ref_clk(ref_clk), .sys_rst(sys_rst),
      .program_allow(memWe), .wrAddr(memWaddr), .wrData(memWdata),
      .fetch_allow(memRe), .rdAddr(addrReg), .rdData(memRdata)
   );

   // Counted on the system clock; lengths scale with ref_clk
   dee_timer #(.CNT_W(CNT_W)) u_timer (
      .ref_clk(ref_clk), .sys_rst(sys_rst),
      .start(timerStart), .load(timerLoad), .done(timerDone)
   );

   // ==================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_fetch_start: assert property (startFetch |=> state == ST_RD_ISSUE ##1 fetchGo ##1 !fetchGo)
      else $error("fetch did not run");
   chk_fetch_ignore: assert property (ctrlWr && pwdata[`DEE_C_FETCH_GO] && !fetchAllow |=> !fetchGo)
      else $error("fetch started without allow");
   chk_read_hold: assert property (state == ST_RD_TAKE |=> dataReg == $past(memRdata))
      else $error("read byte not presented");
   chk_page_step: assert property (state == ST_RD_TAKE && pageMode && addrReg[3:0] != 4'hF
      |=> addrReg == {$past(addrReg[6:4]), $past(addrReg[3:0]) + 4'h1})
      else $error("page read did not advance");
   chk_low_saturate: assert property ((tagWr || state == ST_RD_TAKE) && addrReg[3:0] == 4'hF
      |=> addrReg[3:0] == 4'hF && $stable(addrReg[6:4]))
      else $error("lower field rolled over");
   chk_tag_clear: assert property (wipeAllowPrev && !wipeAllow |=> tagBuf == 16'h0000)
      else $error("tags kept after allow fell");
   chk_tag_mark: assert property (tagWr |=> tagBuf[$past(addrReg[3:0])])
      else $error("data write did not tag");
   chk_wipe_end: assert property (wipeEnd |=> !wipeGo && wipeAllow ##1 !wipeAllow)
      else $error("erase end order wrong");
   chk_erase_zero: assert property (state == ST_WIPE_APPLY && tagBuf[eraseIdx]
      |-> memWe && memWdata == 8'h00)
      else $error("tagged byte not zeroed");
   chk_prog_ignore: assert property (ctrlWr && pwdata[`DEE_C_PROG_GO] && !programAllow |=> !programGo)
      else $error("write started without allow");
   chk_prog_end: assert property (progEnd |=> !programGo && programAllow ##1 !programAllow)
      else $error("write end order wrong");
   chk_erase_first: assert property (startProgram |=> memWe && memWdata == 8'h00 ##1 state == ST_WR_WAIT)
      else $error("byte write skipped erase");
   chk_timer_len: assert property (state == ST_WR_CLEAR && !timingSel
      |-> timerLoad == CNT_W'(WRITE_SHORT_CYC))
      else $error("wrong write length");
   chk_wipe_ignore: assert property (ctrlWr && pwdata[`DEE_C_WIPE_GO] && !wipeAllow |=> !wipeGo)
      else $error("erase started without allow");
   chk_done_set: assert property (doneEvt |=> nvmDoneFlag)
      else $error("done flag not set");
   chk_busy_lock: assert property (!idle && wrTake |=> $stable(addrReg) || state == ST_IDLE)
      else $error("register changed while busy");

   cov_byte_read: cover property (startFetch && !pageMode ##3 idle);
   cov_page_park: cover property (state == ST_RD_TAKE && pageMode && addrReg[3:0] == 4'hF);
   cov_erase: cover property (wipeEnd ##1 state == ST_FINISH);
   cov_write: cover property (progEnd && timingSel);

endmodule

// ### hdl/dee_mem.sv
`timescale 1ns/1ps

module dee_mem #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic program_allow,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [DW-1:0] wrData,
   input wire logic fetch_allow,
   input wire logic [AW-1:0] rdAddr,
   output logic [DW-1:0] rdData
);

   // Array is not reset: contents are meant to survive
   logic [DW-1:0] cells [0:(1<<AW)-1];

   // Write port
   always_ff @(posedge ref_clk) begin
      if (program_allow) begin
         cells[wrAddr] <= wrData;
      end
   end

   // Registered read port
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdData <= '0;
      end else if (fetch_allow) begin
         rdData <= cells[rdAddr];
      end
   end

endmodule

// ### hdl/dee_pkg.sv
package dee_pkg;

   typedef logic [31:0] dee_word_t;
   typedef logic [7:0] dee_byte_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD_ISSUE = 3'b001,
      ST_RD_TAKE = 3'b010,
      ST_WIPE_WAIT = 3'b011,
      ST_WIPE_APPLY = 3'b100,
      ST_WR_CLEAR = 3'b101,
      ST_WR_WAIT = 3'b110,
      ST_FINISH = 3'b111
   } dee_state_t;

endpackage

// ### hdl/dee_timer.sv
`timescale 1ns/1ps

module dee_timer #(
   parameter int CNT_W = 18
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [CNT_W-1:0] load,
   output logic done
);

   logic [CNT_W-1:0] count;
   logic running;

   // Down counter; done pulses after exactly load cycles
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         count <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            count <= load;
            running <= 1'b1;
         end else if (running) begin
            if (count <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   chk_timer_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
      done |=> !done)
      else $error("timer done longer than one cycle");

endmodule

// ### test/dee_cpu_model.sv
`timescale 1ns/1ps
`include "dee_cfg.svh"
// ==================================================
// CPU side bus master
module dee_cpu_model (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [`DEE_APB_AW-1:0] paddr,
   output dee_pkg::dee_word_t pwdata,
   input wire dee_pkg::dee_word_t prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import dee_pkg::*;

   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // One transfer, held until pready is seen; no interrupt service runs here,
   // so an enable and go pair is never split by other traffic
   task automatic xfer(input logic w, input logic [7:0] a, input dee_word_t d,
      output dee_word_t r, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data lines show the inverse, so stale data is never mistaken
      pwdata <= ~d;
   endtask
endmodule

// ### test/tb_data_eeprom_access_controller.sv
`timescale 1ns/1ps
`include "dee_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
$display("ERROR %0t: mismatch got %0h exp %0h", $time, (g), (e)); end end
module tb_data_eeprom_access_controller;
   import dee_pkg::*;
   // Short cycle counts keep the run brief; the order of lengths is kept
   localparam int ES = 20;
   localparam int WS = 12;
   localparam int EL = 24;
   localparam int WL = 16;
   localparam int LIMIT = 20000;
   localparam logic [7:0] OA = `DEE_OFS_ADDR;
   localparam logic [7:0] OD = `DEE_OFS_DATA;
   localparam logic [7:0] OC = `DEE_OFS_CTRL;
   localparam logic [7:0] OS = `DEE_OFS_STAT;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, nvmDoneFlag, err;
   logic [`DEE_APB_AW-1:0] paddr;
   dee_word_t pwdata, prdata, rd;
   int errors = 0;
   int compares = 0;
   int cyc = 0;

   // ==================================================
   // Clock, design and bus master
   always #10 ref_clk = ~ref_clk;

   dee_ctrl #(.ERASE_SHORT_CYC(ES), .WRITE_SHORT_CYC(WS), .ERASE_LONG_CYC(EL), .WRITE_LONG_CYC(WL)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nvmDoneFlag(nvmDoneFlag));

   dee_cpu_model cpu (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // ==================================================
   // Shared tasks
   task automatic end_sim;
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input dee_word_t d);
      cpu.xfer(1'b1, a, d, rd, err);
   endtask

   task automatic rdc(input logic [7:0] a, input dee_word_t e);
      cpu.xfer(1'b0, a, 32'h0, rd, err);
      `CHK(rd, e)
   endtask

   // Poll a go bit until it falls; elapsed cycles must lie in the window
   task automatic waitGo(input int pos, input int t0, input int lo, input int hi);
      int n = 0;
      do begin
         cpu.xfer(1'b0, OC, 32'h0, rd, err);
         n++;
      end while (rd[pos] !== 1'b0 && n < 300);
      `CHK((cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1)
   endtask

   // Done flag set at cycle end, then cleared by writing one
   task automatic doneClear;
      rdc(OS, 32'h1);
      `CHK(nvmDoneFlag, 1'b1)
      wr(OS, 32'h1);
      rdc(OS, 32'h0);
      `CHK(nvmDoneFlag, 1'b0)
   endtask

   // ==================================================
   // Scenarios
   task automatic t_reset;
      rdc(OA, 32'h0);
      rdc(OD, 32'h0);
      rdc(OC, 32'h0);
      rdc(OS, 32'h0);
      cpu.xfer(1'b0, 8'h10, 32'h0, rd, err);
      `CHK({err, rd}, 33'h1_0000_0000)
   endtask

   task automatic t_refuse;
      wr(OC, 32'h25);
      rdc(OC, 32'h0);
      wr(OC, 32'h30);
      rdc(OC, 32'h10);
      rdc(OS, 32'h0);
      wr(OC, 32'h0);
   endtask

   task automatic t_write(input logic [7:0] a, input logic [7:0] d, input logic tim, input int n);
      int t0;
      wr(OA, {24'h0, a});
      wr(OD, {24'h0, d});
      wr(OC, {24'h0, tim, 7'h08});
      wr(OC, {24'h0, tim, 7'h0C});
      t0 = cyc;
      rdc(OS, 32'h2);
      wr(OA, 32'h7F);
      // Zeroing step, timer and one-cycle finish, seen through a four-cycle poll
      waitGo(2, t0, n + 2, n + 7);
      rdc(OC, {24'h0, tim, 7'h00});
      rdc(OA, {24'h0, a});
      doneClear();
   endtask

   // Fetch with the allow bit already stored
   task automatic trig(input logic pg, input logic [7:0] d, input logic [7:0] a);
      wr(OC, {27'h0, pg, 4'h3});
      waitGo(0, cyc, 0, 12);
      rdc(OD, {24'h0, d});
      rdc(OA, {24'h0, a});
   endtask

   task automatic t_read(input logic [7:0] a, input logic pg, input logic [7:0] d, input logic [7:0] ea);
      wr(OA, {24'h0, a});
      wr(OC, {27'h0, pg, 4'h2});
      trig(pg, d, ea);
   endtask

   // Tag one byte, optionally drop the tags by lowering wipe allow, then erase
   task automatic t_erase(input logic [7:0] a, input logic drop, input logic tim, input int n);
      int t0;
      wr(OC, 32'h10);
      wr(OA, {24'h0, a});
      wr(OD, 32'hFF);
      rdc(OA, {24'h0, a[7:4], a[3:0] == 4'hF ? 4'hF : a[3:0] + 4'h1});
      wr(OC, 32'h50);
      if (drop) begin
         wr(OC, 32'h10);
         wr(OC, 32'h50);
      end
      wr(OC, {24'h0, tim, 7'h70});
      t0 = cyc;
      // Timer, sixteen apply slots, then the poll granularity
      waitGo(5, t0, n + 18, n + 23);
      rdc(OC, {24'h0, tim, 7'h10});
      doneClear();
   endtask

   // ==================================================
   // Main sequence and hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors++;
         end_sim();
      end
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_refuse();
      t_write(8'h2E, 8'h3C, 1'b0, WS);
      t_write(8'h2F, 8'h5A, 1'b1, WL);
      t_read(8'h2E, 1'b0, 8'h3C, 8'h2E);
      t_read(8'h2E, 1'b1, 8'h3C, 8'h2F);
      trig(1'b1, 8'h5A, 8'h2F);
      t_erase(8'h2F, 1'b1, 1'b0, ES);
      t_read(8'h2F, 1'b0, 8'h5A, 8'h2F);
      t_erase(8'h2E, 1'b0, 1'b1, EL);
      t_read(8'h2E, 1'b0, 8'h00, 8'h2E);
      t_read(8'h2F, 1'b0, 8'h5A, 8'h2F);
      end_sim();
   end
endmodule
